// ==== include/error_history_pkg.sv ====
// Constants, field layout and answer codes of the error history stack.
// Assumes a single clock domain; shared by the stack and its slot memory.
package error_history_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int SLOT_COUNT = 8;
    localparam int PTR_W      = 3;
    localparam int CNT_W      = 4;
    localparam int WORD_W     = 32;

    // ------------------------------------------------------------------
    // Subindices
    // ------------------------------------------------------------------
    localparam logic [7:0] SUBIDX_COUNT = 8'h00;
    localparam logic [7:0] SUBIDX_FIRST = 8'h01;
    localparam logic [7:0] SUBIDX_SIX   = 8'h06;
    localparam logic [7:0] SUBIDX_SEVEN = 8'h07;
    localparam logic [7:0] SUBIDX_EIGHT = 8'h08;

    // ------------------------------------------------------------------
    // Error word layout
    // ------------------------------------------------------------------
    localparam int NUMBER_LSB = 0;
    localparam int CLASS_LSB  = 8;
    localparam int CODE_LSB   = 16;
    localparam logic [15:0] ERR_CODE_GENERAL = 16'h1000;

    // ------------------------------------------------------------------
    // Reset values and count ceiling
    // ------------------------------------------------------------------
    localparam logic [WORD_W-1:0] SLOT_RESET  = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  COUNT_RESET = 4'h0;
    localparam logic [PTR_W-1:0]  PTR_RESET   = 3'h0;
    localparam logic [CNT_W-1:0]  COUNT_MAX   = 4'h8;

    // ------------------------------------------------------------------
    // Abort codes
    // ------------------------------------------------------------------
    localparam logic [31:0] ABORT_NO_DATA   = 32'h0800_0024;
    localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
    localparam logic [31:0] ABORT_BAD_VALUE = 32'h0609_0030;
    localparam logic [31:0] ABORT_NO_SUBIDX = 32'h0609_0011;
    localparam logic [31:0] ABORT_NONE      = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH
    } answer_state_e;

endpackage

// ==== include/slot_mem_if.sv ====
// Carrier between the stack controller and its slot memory.
// Assumes one clock; read data arrive one cycle after rd_en.
`timescale 1ns/1ps
interface slot_mem_if;
    import error_history_pkg::*;
    logic              wr_en;
    logic [PTR_W-1:0]  wr_addr;
    logic [WORD_W-1:0] wr_data;
    logic              rd_en;
    logic [PTR_W-1:0]  rd_addr;
    logic [WORD_W-1:0] rd_data;

    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// ==== rtl/error_history_stack.sv ====
// Error history stack: eight error words, newest first, plus a count.
// Assumes requests and error events are synchronous to clock.
`timescale 1ns/1ps

module error_history_stack
    import error_history_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        err_valid,
    input  wire logic [7:0]  err_number,
    input  wire logic [15:0] err_code,
    input  wire logic [7:0]  err_class_obj,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [7:0]  req_subindex,
    input  wire logic [31:0] req_wdata,
    output logic             rsp_valid,
    output logic             rsp_abort,
    output logic [31:0]      rsp_data,
    output logic [31:0]      rsp_abort_code,
    output logic [CNT_W-1:0] err_count
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Slot memory
    // ------------------------------------------------------------------
    slot_mem_if mem_bus ();

    slot_memory u_mem (
        .clock (clock),
        .rst_n (rst_n_q),
        .port  (mem_bus.mem)
    );

    // Memory location of history slot k, newest one behind the write pointer
    function automatic logic [PTR_W-1:0] slot_addr(input logic [PTR_W-1:0] wp,
                                                   input logic [7:0]       sub);
        return PTR_W'(wp - sub[PTR_W:0]);
    endfunction

    // A write of zero to the count is the only write that is accepted
    function automatic logic is_zero(input logic [WORD_W-1:0] w);
        return (w == '0);
    endfunction

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    answer_state_e     state_q;
    logic [PTR_W-1:0]  wp_q;
    logic [CNT_W-1:0]  count_q;
    logic              take;
    logic              is_slot;
    logic              clear_req;
    logic              slot_live;
    logic              live_q;

    assign req_ready = (state_q == ST_IDLE);
    assign take      = req_valid && req_ready;
    assign is_slot   = (req_subindex >= SUBIDX_FIRST) && (req_subindex <= SUBIDX_EIGHT);
    assign clear_req = take && req_write && (req_subindex == SUBIDX_COUNT)
                       && is_zero(req_wdata);
    assign slot_live = ({4'h0, count_q} >= req_subindex);
    assign err_count = count_q;

    // ------------------------------------------------------------------
    // Push of a new error word
    // ------------------------------------------------------------------
    always_comb
    begin
        mem_bus.wr_en   = err_valid;
        mem_bus.wr_addr = wp_q;
        mem_bus.wr_data = {err_code,
                           err_class_obj,
                           err_number};
        mem_bus.rd_en   = take && !req_write && is_slot && (count_q != COUNT_RESET);
        mem_bus.rd_addr = slot_addr(wp_q, req_subindex);
    end

    // Advancing the pointer renumbers every slot up by one; the word
    // eight behind is overwritten and so falls off the end.
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            wp_q <= PTR_RESET;
        else if (err_valid)
            wp_q <= PTR_W'(wp_q + 3'h1);
    end

    // ------------------------------------------------------------------
    // Error count; a push in the clearing cycle still counts
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            count_q <= COUNT_RESET;
        else if (clear_req && err_valid)
            count_q <= CNT_W'(1);
        else if (clear_req)
            count_q <= COUNT_RESET;
        else if (err_valid && count_q != COUNT_MAX)
            count_q <= CNT_W'(count_q + 4'h1);
    end

    // ------------------------------------------------------------------
    // Answer sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            state_q <= ST_IDLE;
        else
        begin
            unique case (state_q)
                ST_IDLE:  if (mem_bus.rd_en) state_q <= ST_FETCH;
                ST_FETCH: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Slot liveness at the take
    // ------------------------------------------------------------------
    // Slots above the count since a restart read as zero, not as old words
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            live_q <= 1'b0;
        else if (take)
            live_q <= slot_live;
    end

    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rsp_valid      <= 1'b0;
            rsp_abort      <= 1'b0;
            rsp_data       <= SLOT_RESET;
            rsp_abort_code <= ABORT_NONE;
        end
        else
        begin
            rsp_valid      <= 1'b0;
            rsp_abort      <= 1'b0;
            rsp_data       <= SLOT_RESET;
            rsp_abort_code <= ABORT_NONE;
            if (state_q == ST_FETCH)
            begin
                rsp_valid <= 1'b1;
                rsp_data  <= live_q ? mem_bus.rd_data : SLOT_RESET;
            end
            else if (take && req_subindex == SUBIDX_COUNT)
            begin
                rsp_valid <= 1'b1;
                if (req_write && !is_zero(req_wdata))
                begin
                    rsp_abort      <= 1'b1;
                    rsp_abort_code <= ABORT_BAD_VALUE;
                end
                else if (!req_write)
                    rsp_data <= {28'h0000000, count_q};
            end
            else if (take && is_slot && req_write)
            begin
                rsp_valid      <= 1'b1;
                rsp_abort      <= 1'b1;
                rsp_abort_code <= ABORT_READ_ONLY;
            end
            else if (take && is_slot && count_q == COUNT_RESET)
            begin
                rsp_valid      <= 1'b1;
                rsp_abort      <= 1'b1;
                rsp_abort_code <= ABORT_NO_DATA;
            end
            else if (take && !is_slot)
            begin
                rsp_valid      <= 1'b1;
                rsp_abort      <= 1'b1;
                rsp_abort_code <= ABORT_NO_SUBIDX;
            end
        end
    end

endmodule // error_history_stack

// ==== rtl/slot_memory.sv ====
// Eight-word storage for the error history with registered read data.
// Assumes synchronous reset release from the stack controller.
`timescale 1ns/1ps
module slot_memory
    import error_history_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    slot_mem_if.mem   port
);

    logic [WORD_W-1:0] words_q [SLOT_COUNT];

    // ------------------------------------------------------------------
    // Storage, preset to zero
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < SLOT_COUNT; i++)
                words_q[i] <= SLOT_RESET;
        end
        else if (port.wr_en)
        begin
            words_q[port.wr_addr] <= port.wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Read port, old data on a same-address write
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            port.rd_data <= SLOT_RESET;
        else if (port.rd_en)
            port.rd_data <= words_q[port.rd_addr];
    end

endmodule // slot_memory

// ==== verification/error_history_stack_chk.sv ====
// Port checker for the error history stack.
// Assumes it is bound onto error_history_stack.
`timescale 1ns/1ps
module error_history_stack_chk
    import error_history_pkg::*;
(
    input wire logic             clock,
    input wire logic             arst_n,
    input wire logic             err_valid,
    input wire logic             req_valid,
    input wire logic             req_ready,
    input wire logic             req_write,
    input wire logic [7:0]       req_subindex,
    input wire logic [31:0]      req_wdata,
    input wire logic             rsp_valid,
    input wire logic             rsp_abort,
    input wire logic [31:0]      rsp_abort_code,
    input wire logic [CNT_W-1:0] err_count
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire tk  = req_valid && req_ready;
    wire rd  = tk && !req_write;
    wire slt = req_subindex != 8'h00 && req_subindex <= 8'h08;
    wire clr = tk && req_write && req_subindex == 8'h00 && req_wdata == 32'h0;
    cnt_step_a: assert property (err_valid && !clr && err_count < COUNT_MAX
        |=> err_count == $past(err_count) + 4'h1) else $error("count missed a push");
    cnt_sat_a: assert property (err_valid && !clr && err_count == COUNT_MAX
        |=> err_count == COUNT_MAX) else $error("count left its ceiling");
    cnt_hold_a: assert property (!err_valid && !clr
        |=> $stable(err_count)) else $error("count moved without cause");
    cnt_clear_a: assert property (clr && !err_valid
        |=> err_count == 4'h0) else $error("count not restarted");
    empty_abort_a: assert property (rd && slt && err_count == 4'h0
        |=> rsp_valid && rsp_abort && rsp_abort_code == ABORT_NO_DATA) else $error("no abort");
    slot_fetch_a: assert property (rd && slt && err_count != 4'h0
        |=> !req_ready ##1 rsp_valid && !rsp_abort) else $error("slot read answer late");
    ro_write_a: assert property (tk && req_write && slt
        |=> rsp_abort && rsp_abort_code == ABORT_READ_ONLY) else $error("slot write taken");
    abort_valid_a: assert property (rsp_abort |-> rsp_valid) else $error("stray abort");
    clear_push_a: assert property (clr && err_valid
        |=> err_count == 4'h1) else $error("push lost in clearing cycle");
    cover property (clr);
    cover property (clr && err_valid);
    cover property (err_valid && err_count == COUNT_MAX);
    cover property (rd && slt && err_count != 4'h0);
endmodule // error_history_stack_chk

bind error_history_stack error_history_stack_chk chk (.*);

// ==== verification/od_master.sv ====
// Fieldbus master model making object dictionary accesses.
// Assumes the stack answers within a few cycles of the take.
`timescale 1ns/1ps
module od_master
(
    input  wire logic        clock,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_abort,
    input  wire logic [31:0] rsp_data,
    input  wire logic [31:0] rsp_abort_code,
    output logic             req_valid,
    output logic             req_write,
    output logic [7:0]       req_subindex,
    output logic [31:0]      req_wdata
);
    // ------------------------------------------------------------------
    // Access task: hold until taken, released lines show inverse
    // ------------------------------------------------------------------
    logic        got_valid;
    logic        got_abort;
    logic [31:0] got_data;
    logic [31:0] got_code;
    initial
    begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_subindex = 8'h00;
        req_wdata = 32'h0;
    end
    task automatic access(input logic w, input logic [7:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_subindex <= s;
        req_wdata <= d;
        @(negedge clock);
        while (!req_ready && n < 20)
        begin
            n++;
            @(negedge clock);
        end
        @(posedge clock);
        req_valid <= 1'b0;
        req_write <= !w;
        req_subindex <= ~s;
        req_wdata <= ~d;
        n = 0;
        @(negedge clock);
        while (!rsp_valid && n < 20)
        begin
            n++;
            @(negedge clock);
        end
        got_valid = rsp_valid;
        got_abort = rsp_abort;
        got_data = rsp_data;
        got_code = rsp_abort_code;
    endtask
endmodule // od_master

// ==== verification/tb_error_history_stack.sv ====
// Testbench for the error history stack against a queue model.
// Assumes od_master drives the request port.
`timescale 1ns/1ps
module tb_error_history_stack
    import error_history_pkg::*;
;
    logic             clock, arst_n, err_valid, req_valid, req_ready, req_write;
    logic             rsp_valid, rsp_abort;
    logic [7:0]       err_number, err_class_obj, req_subindex;
    logic [15:0]      err_code;
    logic [31:0]      req_wdata, rsp_data, rsp_abort_code;
    logic [CNT_W-1:0] err_count;
    int               miscompares, n_checks, cnt;
    int unsigned      seed = 54;
    logic [31:0]      hist[$];
    error_history_stack DUT (.*);
    od_master master (.*);
    // ------------------------------------------------------------------
    // Model and helpers
    // ------------------------------------------------------------------
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic pushes(int k);
        logic [31:0] r;
        repeat (k)
        begin
            r = rnd();
            @(posedge clock);
            err_valid <= 1'b1;
            err_number <= r[7:0];
            err_class_obj <= r[15:8];
            err_code <= r[31:16];
            hist.push_front(r);
            if (hist.size() > SLOT_COUNT) void'(hist.pop_back());
            if (cnt < SLOT_COUNT) cnt++;
        end
        @(posedge clock);
        err_valid <= 1'b0;
        @(negedge clock);
        chk("err_count", err_count, cnt);
    endtask
    task automatic op(logic w, logic [7:0] s, logic [31:0] d);
        logic [31:0] ed, ec;
        ed = 0;
        ec = ABORT_NONE;
        if (s == 8'h00 && w && d != 0) ec = ABORT_BAD_VALUE;
        else if (s == 8'h00 && w) cnt = 0;
        else if (s == 8'h00) ed = cnt;
        else if (s > 8'h08) ec = ABORT_NO_SUBIDX;
        else if (w) ec = ABORT_READ_ONLY;
        else if (cnt == 0) ec = ABORT_NO_DATA;
        else if (s <= cnt) ed = hist[s-1];
        master.access(w, s, d);
        chk("rsp_valid", master.got_valid, 1);
        chk("rsp_abort", master.got_abort, ec != ABORT_NONE);
        chk("rsp_data", master.got_data, ed);
        chk("abort_code", master.got_code, ec);
        chk("err_count", err_count, cnt);
    endtask
    task automatic read_all();
        for (int s = 0; s <= 8; s++) op(1'b0, 8'(s), 32'h0);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        #200us;
        miscompares++;
        wrap_up();
    end
    initial
    begin
        {arst_n, err_valid, err_number, err_class_obj, err_code} = '0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        for (int s = 0; s <= 9; s++) op(1'b0, 8'(s), 32'h0);
        for (int s = 6; s <= 8; s++) op(1'b1, 8'(s), rnd());
        op(1'b1, SUBIDX_COUNT, rnd() | 32'h1);
        pushes(3);
        read_all();
        pushes(7);
        read_all();
        op(1'b1, SUBIDX_COUNT, 32'h0);
        op(1'b0, SUBIDX_FIRST, 32'h0);
        pushes(1);
        read_all();
        fork
            pushes(1);
            op(1'b1, SUBIDX_COUNT, 32'h0);
        join
        read_all();
        @(posedge clock);
        arst_n <= 1'b0;
        @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        cnt = 0;
        hist.delete();
        op(1'b0, SUBIDX_COUNT, 32'h0);
        op(1'b0, SUBIDX_FIRST, 32'h0);
        wrap_up();
    end
endmodule // tb_error_history_stack
